/* File: design/bdu_top.sv */
// Breakpoint and debug-status unit of the core
// Operation
// - Access type: 00 execute, 01 write, 11 read or write, 10 unused
// - Match size: 00 one byte, 01 two, 11 four, 10 unused
// - Global enable arms breakpoint for all tasks, kept on task switch
// - Local enable arms breakpoint for current task, cleared on task switch
// - Guard bit blocks debug register access; cleared on any debug exception
// - Hit flags set on a debug exception for every matching breakpoint, even when not enabled
// - Task-switch flag set before handler when switched task has trap bit
// - Single-step flag set when exception came from trap flag bit 8
// - Status is never auto-cleared; software clears it
// - With trap flag set, exception after every executed instruction
// - Breakpoint opcode execution raises a code breakpoint exception
// - Four breakpoint registers hold full 32-bit linear addresses
// - Execute breakpoints are taken before the instruction executes
// - Debug registers accessed only by moves at privilege level 0
`timescale 1ns/1ps
`default_nettype none
`include "bdu_defines.svh"
module bdu_top
	import bdu_pkg::*;
#(
	parameter int NBP = 4
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Pipeline access stage
	input  wire bdu_access_t acc,
	input  wire logic        insn_retire,
	input  wire logic [31:0] cpu_flags_word,
	input  wire logic        breakpoint_opcode,
	input  wire logic        task_switch,
	input  wire logic        task_state_segment_trap,
	// Move instruction port
	input  wire bdu_move_t   mov,
	output logic [31:0]      mov_rdata,
	output logic             mov_done,
	output logic             mov_fault,
	// Exception outputs
	output logic             acc_block,
	output logic             debug_exc,
	output logic             code_bp_exc,
	output bdu_cause_t       cause,
	// Register views
	output logic [31:0]      debug_control_reg,
	output logic [31:0]      debug_status_reg
);

	logic [31:0]            ctl_q;
	logic [31:0]            ctl_d;
	logic [31:0]            sts_q;
	logic [31:0]            sts_d;
	logic [NBP-1:0][31:0]   bp_addr_q;
	logic [NBP-1:0]         hit;
	logic [NBP-1:0]         armed;
	logic                   task_pend_q;
	logic                   trap_flag;
	logic                   bp_fire;
	logic                   ss_fire;
	logic                   guard_fire;
	logic                   exc;
	logic                   mov_ok;
	logic                   mov_wr_ctl;
	logic                   mov_wr_bp;
	logic [31:0]            rdata_d;

	function automatic logic [1:0] fld(input logic [31:0] c, input int pos);
		fld = c[pos +: 2];
	endfunction

	assign trap_flag = cpu_flags_word[`BDU_TRAP_BIT];

	// Move decode
	assign guard_fire = mov.valid && ctl_q[`BDU_CTL_GUARD];
	assign mov_ok     = mov.valid && !guard_fire && mov.cpl == 2'h0;
	assign mov_wr_ctl = mov_ok && mov.write && mov.sel == `BDU_SEL_CONTROL;
	assign mov_wr_bp  = mov_ok && mov.write && mov.sel[2] == 1'b0;

	bdu_regfile #(.NBP(NBP)) u_regs (
		.clk       (clk),
		.rstn      (rstn),
		.wr_en     (mov_wr_bp),
		.wr_idx    (mov.sel[1:0]),
		.wr_data   (mov.wdata),
		.bp_addr_q (bp_addr_q)
	);

	genvar g;
	generate
		for (g = 0; g < NBP; g++) begin : g_cmp
			bdu_match u_match (
				.bp_addr            (bp_addr_q[g]),
				.access_type_select (fld(ctl_q, `BDU_CTL_TYPE0 + `BDU_CTL_FSTRIDE * g)),
				.match_size         (fld(ctl_q, `BDU_CTL_SIZE0 + `BDU_CTL_FSTRIDE * g)),
				.acc                (acc),
				.hit                (hit[g])
			);
			assign armed[g] = ctl_q[`BDU_CTL_GLOBAL0 + 2 * g] ||
				ctl_q[`BDU_CTL_LOCAL0 + 2 * g];
		end
	endgenerate

	// Any armed hit, execute or data, blocks the access so the instruction does not complete
	assign bp_fire   = |(hit & armed);
	assign acc_block = bp_fire;
	assign ss_fire   = insn_retire && trap_flag;
	assign exc       = bp_fire || ss_fire || guard_fire;

	// Control register
	always_comb begin
		ctl_d = ctl_q;
		if (mov_wr_ctl) begin
			ctl_d = (mov.wdata & `BDU_CTL_WMASK) | `BDU_CTL_RESET;
		end
		if (task_switch) begin
			ctl_d = ctl_d & ~`BDU_CTL_LOCMASK;
		end
		if (exc) begin
			ctl_d[`BDU_CTL_GUARD] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctl_q <= `BDU_CTL_RESET;
		end else begin
			ctl_q <= ctl_d;
		end
	end

	// Task trap pending until the next debug entry
	always_ff @(posedge clk) begin
		if (!rstn) begin
			task_pend_q <= 1'b0;
		end else if (task_switch) begin
			task_pend_q <= task_state_segment_trap && !exc;
		end else if (exc) begin
			task_pend_q <= 1'b0;
		end
	end

	// Status register: sticky, writable only by software
	always_comb begin
		sts_d = sts_q;
		if (mov_ok && mov.write && mov.sel == `BDU_SEL_STATUS) begin
			sts_d = mov.wdata & {16'h0, 2'h3, 10'h0, 4'hf};
		end
		if (exc) begin
			sts_d[NBP-1:0] = sts_d[NBP-1:0] | hit;
			if (ss_fire) begin
				sts_d[`BDU_STS_SSTEP] = 1'b1;
			end
			if (task_pend_q || (task_switch && task_state_segment_trap)) begin
				sts_d[`BDU_STS_TASK] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sts_q <= `BDU_STS_RESET;
		end else begin
			sts_q <= sts_d;
		end
	end

	// Move read data
	always_comb begin
		unique case (mov.sel)
			`BDU_SEL_BP0:     rdata_d = bp_addr_q[0];
			`BDU_SEL_BP1:     rdata_d = bp_addr_q[1];
			`BDU_SEL_BP2:     rdata_d = bp_addr_q[2];
			`BDU_SEL_BP3:     rdata_d = bp_addr_q[3];
			`BDU_SEL_STATUS:  rdata_d = sts_q;
			`BDU_SEL_CONTROL: rdata_d = ctl_q;
			default:          rdata_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mov_rdata <= 32'h0;
			mov_done  <= 1'b0;
			mov_fault <= 1'b0;
		end else begin
			mov_rdata <= (mov_ok && !mov.write) ? rdata_d : 32'h0;
			mov_done  <= mov_ok;
			mov_fault <= mov.valid && !mov_ok;
		end
	end

	// Exception reporting
	always_ff @(posedge clk) begin
		if (!rstn) begin
			debug_exc   <= 1'b0;
			code_bp_exc <= 1'b0;
			cause       <= '0;
		end else begin
			debug_exc   <= exc;
			code_bp_exc <= breakpoint_opcode;
			cause       <= '{breakpoint: bp_fire, sstep: ss_fire,
				task_trap: task_pend_q || (task_switch && task_state_segment_trap),
				guard: guard_fire,
				code_bp: breakpoint_opcode,
				priv: mov.valid && !guard_fire && mov.cpl != 2'h0};
		end
	end

	assign debug_control_reg = ctl_q;
	assign debug_status_reg  = sts_q;

	property p_guard_clear;
		@(posedge clk) disable iff (!rstn) exc |=> !ctl_q[`BDU_CTL_GUARD];
	endproperty
	a_guard_clear: assert property (p_guard_clear) else $error("guard kept after exception");

	property p_local_clear;
		@(posedge clk) disable iff (!rstn)
			task_switch |=> (ctl_q & `BDU_CTL_LOCMASK) == 32'h0;
	endproperty
	a_local_clear: assert property (p_local_clear) else $error("local enable survived");

	property p_global_keep;
		@(posedge clk) disable iff (!rstn)
			task_switch && !mov_wr_ctl |=> ctl_q[7:0] ==
				($past(ctl_q[7:0]) & 8'haa);
	endproperty
	a_global_keep: assert property (p_global_keep) else $error("global enable changed");

	property p_hit_flag;
		@(posedge clk) disable iff (!rstn)
			exc |=> (sts_q[NBP-1:0] & $past(hit)) == $past(hit);
	endproperty
	a_hit_flag: assert property (p_hit_flag) else $error("hit flag missing");

	property p_sstep;
		@(posedge clk) disable iff (!rstn)
			insn_retire && trap_flag |=> debug_exc && sts_q[`BDU_STS_SSTEP];
	endproperty
	a_sstep: assert property (p_sstep) else $error("single step not raised");

	property p_sticky;
		@(posedge clk) disable iff (!rstn)
			!(mov.valid && mov.write) |=> (sts_q & $past(sts_q)) == $past(sts_q);
	endproperty
	a_sticky: assert property (p_sticky) else $error("status cleared by hardware");

	property p_fixed;
		@(posedge clk) disable iff (!rstn)
			ctl_q[`BDU_CTL_FIXED1] && ctl_q[15:14] == 2'h0 && ctl_q[12:11] == 2'h0 &&
				ctl_q[9:8] == 2'h0;
	endproperty
	a_fixed: assert property (p_fixed) else $error("reserved control bits moved");

	property p_guard_fault;
		@(posedge clk) disable iff (!rstn)
			mov.valid && ctl_q[`BDU_CTL_GUARD] |=> mov_fault && !mov_done && debug_exc;
	endproperty
	a_guard_fault: assert property (p_guard_fault) else $error("guarded move completed");

	property p_priv;
		@(posedge clk) disable iff (!rstn)
			mov.valid && mov.cpl != 2'h0 |=> !mov_done;
	endproperty
	a_priv: assert property (p_priv) else $error("move done outside level 0");

	property p_exec_block;
		@(posedge clk) disable iff (!rstn)
			bp_fire && acc.kind == BDU_ACC_FETCH |-> acc_block ##1 debug_exc;
	endproperty
	a_exec_block: assert property (p_exec_block) else $error("execute hit not blocked");

	property p_task_flag;
		@(posedge clk) disable iff (!rstn)
			exc && task_pend_q |=> sts_q[`BDU_STS_TASK];
	endproperty
	a_task_flag: assert property (p_task_flag) else $error("task switch flag missing");

	property p_code_bp;
		@(posedge clk) disable iff (!rstn)
			breakpoint_opcode |=> code_bp_exc && cause.code_bp;
	endproperty
	a_code_bp: assert property (p_code_bp) else $error("code breakpoint not raised");

	property p_mov_answer;
		@(posedge clk) disable iff (!rstn)
			mov.valid |=> mov_done != mov_fault;
	endproperty
	a_mov_answer: assert property (p_mov_answer) else $error("move answer missing");

	property p_type_unused;
		@(posedge clk) disable iff (!rstn)
			ctl_q[`BDU_CTL_TYPE0 +: 2] == 2'h2 |-> !hit[0];
	endproperty
	a_type_unused: assert property (p_type_unused) else $error("unused type matched");

	property p_size_unused;
		@(posedge clk) disable iff (!rstn)
			ctl_q[`BDU_CTL_SIZE0 +: 2] == 2'h2 |-> !hit[0];
	endproperty
	a_size_unused: assert property (p_size_unused) else $error("unused size matched");

endmodule
`default_nettype wire

/* File: design/bdu_defines.svh */
// Constants for the breakpoint and debug-status unit
`ifndef BDU_DEFINES_SVH
`define BDU_DEFINES_SVH

// Register selects carried by the move instruction
`define BDU_SEL_BP0      3'h0
`define BDU_SEL_BP1      3'h1
`define BDU_SEL_BP2      3'h2
`define BDU_SEL_BP3      3'h3
`define BDU_SEL_STATUS   3'h6
`define BDU_SEL_CONTROL  3'h7

// Control register fields
`define BDU_CTL_LOCAL0   0
`define BDU_CTL_GLOBAL0  1
`define BDU_CTL_GUARD    13
`define BDU_CTL_TYPE0    16
`define BDU_CTL_SIZE0    18
`define BDU_CTL_FSTRIDE  4
`define BDU_CTL_FIXED1   10
`define BDU_CTL_RESET    32'h0000_0400
`define BDU_CTL_WMASK    32'hffff_20ff
`define BDU_CTL_LOCMASK  32'h0000_0055

// Status register fields
`define BDU_STS_SSTEP    14
`define BDU_STS_TASK     15
`define BDU_STS_RESET    32'h0000_0000

// Access type and size codes
`define BDU_TYPE_EXEC    2'h0
`define BDU_TYPE_WRITE   2'h1
`define BDU_TYPE_RDWR    2'h3
`define BDU_SIZE_1       2'h0
`define BDU_SIZE_2       2'h1
`define BDU_SIZE_4       2'h3

// Flags word trap bit position
`define BDU_TRAP_BIT     8

`endif

/* File: design/bdu_pkg.sv */
// Types for the breakpoint and debug-status unit
package bdu_pkg;

	typedef enum logic [1:0] {
		BDU_ACC_FETCH,
		BDU_ACC_READ,
		BDU_ACC_WRITE,
		BDU_ACC_NONE
	} bdu_acc_t;

	// One access presented by the pipeline
	typedef struct packed {
		logic          valid;
		bdu_acc_t      kind;
		logic [31:0]   lin_addr;
		logic [2:0]    nbytes_m1;
	} bdu_access_t;

	// One move request to a debug register
	typedef struct packed {
		logic          valid;
		logic          write;
		logic [2:0]    sel;
		logic [1:0]    cpl;
		logic [31:0]   wdata;
	} bdu_move_t;

	// Exception causes reported to the dispatch logic
	typedef struct packed {
		logic          breakpoint;
		logic          sstep;
		logic          task_trap;
		logic          guard;
		logic          code_bp;
		logic          priv;
	} bdu_cause_t;

endpackage

/* File: design/bdu_match.sv */
// Address, type and length comparator for one breakpoint
`timescale 1ns/1ps
`default_nettype none
`include "bdu_defines.svh"
module bdu_match
	import bdu_pkg::*;
(
	// Breakpoint setup
	input  wire logic [31:0] bp_addr,
	input  wire logic [1:0]  access_type_select,
	input  wire logic [1:0]  match_size,
	// Access under test
	input  wire bdu_access_t acc,
	// Result
	output logic             hit
);

	logic [31:0] mask;
	logic [31:0] a_lo;
	logic [31:0] a_hi;
	logic        kind_ok;
	logic        size_ok;

	// The unused size code never matches
	always_comb begin
		size_ok = 1'b1;
		unique case (match_size)
			`BDU_SIZE_1: mask = 32'hffff_ffff;
			`BDU_SIZE_2: mask = 32'hffff_fffe;
			`BDU_SIZE_4: mask = 32'hffff_fffc;
			default: begin
				mask    = 32'hffff_ffff;
				size_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		unique case (access_type_select)
			`BDU_TYPE_EXEC:  kind_ok = (acc.kind == BDU_ACC_FETCH);
			`BDU_TYPE_WRITE: kind_ok = (acc.kind == BDU_ACC_WRITE);
			`BDU_TYPE_RDWR:  kind_ok = (acc.kind == BDU_ACC_READ) ||
				(acc.kind == BDU_ACC_WRITE);
			default:         kind_ok = 1'b0;
		endcase
	end

	// First or last byte of the access span falls in the aligned breakpoint window
	assign a_lo = acc.lin_addr & mask;
	assign a_hi = (acc.lin_addr + {29'h0, acc.nbytes_m1}) & mask;
	assign hit  = acc.valid && kind_ok && size_ok &&
		((a_lo == (bp_addr & mask)) || (a_hi == (bp_addr & mask)));

endmodule
`default_nettype wire

/* File: design/bdu_regfile.sv */
// Breakpoint address register bank
`timescale 1ns/1ps
`default_nettype none
module bdu_regfile
	import bdu_pkg::*;
#(
	parameter int NBP = 4
)(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// Write port
	input  wire logic              wr_en,
	input  wire logic [1:0]        wr_idx,
	input  wire logic [31:0]       wr_data,
	// Contents
	output logic [NBP-1:0][31:0]   bp_addr_q
);

	genvar g;
	generate
		for (g = 0; g < NBP; g++) begin : g_bp
			always_ff @(posedge clk) begin
				if (!rstn) begin
					bp_addr_q[g] <= 32'h0;
				end else if (wr_en && wr_idx == 2'(g)) begin
					bp_addr_q[g] <= wr_data;
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* File: test/bdu_pipe_model.sv */
// Pipeline and privileged software model driving the breakpoint unit
`timescale 1ns/1ps
`default_nettype none
module bdu_pipe_model
	import bdu_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Requests to the unit
	output var bdu_access_t acc,
	output var bdu_move_t   mov,
	output logic            insn_retire,
	output logic [31:0]     cpu_flags_word,
	output logic            breakpoint_opcode,
	output logic            task_switch,
	output logic            task_state_segment_trap,
	// Answer from the unit
	input  wire logic       acc_block
);
	initial begin
		acc = '{1'b0, BDU_ACC_NONE, 32'h0, 3'h0};
		mov = '0;
		{insn_retire, breakpoint_opcode, task_switch, task_state_segment_trap} = 4'h0;
		cpu_flags_word = 32'h0000_0002;
	end
	// Software writes reserved control bits freely, uses level 0 unless told, and clears status itself
	task automatic mv(input logic w, input logic [2:0] s, input logic [1:0] p,
		input logic [31:0] d);
		@(negedge clk);
		mov <= '{1'b1, w, s, p, d};
		@(negedge clk);
		mov <= '{1'b0, 1'b0, ~s, ~p, ~d};
	endtask
	task automatic ac(input bdu_acc_t k, input logic [31:0] a, input logic [2:0] n,
		output logic b);
		@(negedge clk);
		acc <= '{1'b1, k, a, n};
		#5 b = acc_block;
		@(negedge clk);
		acc <= '{1'b0, BDU_ACC_NONE, ~a, ~n};
	endtask
	// Bits: trap flag level, retire, breakpoint opcode, task switch, new task trap
	task automatic ev(input logic [4:0] e);
		@(negedge clk);
		cpu_flags_word <= ($urandom & 32'hffff_feff) | {23'h0, e[4], 8'h0};
		{insn_retire, breakpoint_opcode, task_switch, task_state_segment_trap} <= e[3:0];
		@(negedge clk);
		{insn_retire, breakpoint_opcode, task_switch, task_state_segment_trap} <= 4'h0;
	endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking testbench for the breakpoint and debug-status unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bdu_pkg::*;
	logic        clk, rstn, insn_retire, breakpoint_opcode, task_switch;
	logic        task_state_segment_trap, mov_done, mov_fault, acc_block;
	logic        debug_exc, code_bp_exc, blk, ex;
	logic [31:0] cpu_flags_word, mov_rdata, debug_control_reg, debug_status_reg;
	logic [31:0] exp_sts, a;
	bdu_access_t acc;
	bdu_move_t   mov;
	bdu_cause_t  cause;
	logic [35:0] exp_q[$];
	int          err_count, samples_checked, n;
	bdu_acc_t    kinds[3] = '{BDU_ACC_FETCH, BDU_ACC_READ, BDU_ACC_WRITE};
	logic [1:0]  szs[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	logic [1:0]  offs[4] = '{2'h1, 2'h1, 2'h3, 2'h0};
	logic        szex[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	bdu_top #(.NBP(4)) dut (.clk, .rstn, .acc, .insn_retire, .cpu_flags_word,
		.breakpoint_opcode, .task_switch, .task_state_segment_trap, .mov, .mov_rdata,
		.mov_done, .mov_fault, .acc_block, .debug_exc, .code_bp_exc, .cause,
		.debug_control_reg, .debug_status_reg);
	bdu_pipe_model pm (.clk, .acc, .mov, .insn_retire, .cpu_flags_word, .breakpoint_opcode,
		.task_switch, .task_state_segment_trap, .acc_block);

	function automatic logic [35:0] rsp(input logic [3:0] f, input logic [31:0] v);
		return {f, v};
	endfunction

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Result word: done, fault, code breakpoint, debug exception, then status or read data
	always @(negedge clk) begin
		if (rstn === 1'b1 && (mov_done | mov_fault | debug_exc | code_bp_exc) === 1'b1)
			chk({mov_done, mov_fault, code_bp_exc, debug_exc,
				debug_exc ? debug_status_reg : mov_rdata},
				exp_q.size() > 0 ? exp_q.pop_front() : 36'h0);
	end

	task automatic wr(input logic [2:0] s, input logic [31:0] d);
		exp_q.push_back(rsp(4'h8, 32'h0));
		pm.mv(1'b1, s, 2'h0, d);
	endtask

	task automatic rd(input logic [2:0] s, input logic [31:0] e);
		exp_q.push_back(rsp(4'h8, e));
		pm.mv(1'b0, s, 2'h0, 32'h0);
	endtask

	// Access of n+1 bytes that raises an exception when e, recording hit flags h
	task automatic acx(input bdu_acc_t k, input logic [31:0] ad, input logic [2:0] n,
		input logic e, input logic [3:0] h);
		if (e) begin
			exp_sts |= {28'h0, h};
			exp_q.push_back(rsp(4'h1, exp_sts));
		end
		pm.ac(k, ad, n, blk);
		chk({35'h0, blk}, {35'h0, e});
		chk({35'h0, cause.breakpoint}, {35'h0, e});
	endtask

	initial begin
		void'($urandom(5));
		rstn = 1'b0;
		err_count = 0;
		samples_checked = 0;
		exp_sts = 32'h0;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		chk({4'h0, debug_control_reg}, 36'h0_0000_0400);
		chk({4'h0, debug_status_reg}, 36'h0);
		wr(3'h7, 32'hffff_ffff);
		exp_q.push_back(rsp(4'h5, 32'h0));
		pm.mv(1'b0, 3'h7, 2'h0, 32'h0);
		chk({30'h0, cause}, 36'h4);
		rd(3'h7, 32'hffff_04ff);
		exp_q.push_back(rsp(4'h4, 32'h0));
		pm.mv(1'b0, 3'h0, 2'h3, 32'h0);
		chk({30'h0, cause}, 36'h1);
		for (int i = 0; i < 4; i++) begin
			a = $urandom;
			wr(3'(i), a);
			rd(3'(i), a);
		end
		a = $urandom & 32'hffff_fff8;
		wr(3'h0, a);
		wr(3'h1, a);
		wr(3'h6, 32'h0);
		for (int t = 0; t < 4; t++) begin
			for (int k = 0; k < 3; k++) begin
				wr(3'h7, 32'h000c_0402 | (32'(t) << 16));
				ex = (t == 0 && k == 0) || (t == 1 && k == 2) || (t == 3 && k != 0);
				acx(kinds[k], a, 3'h0, ex, {2'h0, k == 0, ex});
			end
		end
		for (int s = 0; s < 4; s++) begin
			wr(3'h7, 32'h0003_0402 | (32'(szs[s]) << 18));
			acx(BDU_ACC_READ, a + 32'(offs[s]), 3'h0, szex[s], {3'h0, szex[s]});
		end
		// Multi-byte accesses: one whose far end reaches the window, one just short
		wr(3'h7, 32'h000f_0402);
		acx(BDU_ACC_WRITE, a - 32'h2, 3'h3, 1'b1, 4'h1);
		acx(BDU_ACC_READ, a - 32'h4, 3'h3, 1'b0, 4'h0);
		wr(3'h6, 32'h0);
		exp_sts = 32'h0;
		wr(3'h7, 32'h0000_00ff);
		pm.ev(5'h03);
		rd(3'h7, 32'h0000_04aa);
		exp_q.push_back(rsp(4'h1, 32'h0000_c000));
		pm.ev(5'h18);
		chk({30'h0, cause}, 36'h18);
		exp_q.push_back(rsp(4'h1, 32'h0000_c000));
		pm.ev(5'h18);
		wr(3'h6, 32'h0);
		exp_q.push_back(rsp(4'h1, 32'h0000_4000));
		pm.ev(5'h1a);
		exp_q.push_back(rsp(4'h1, 32'h0000_c000));
		pm.ev(5'h1b);
		pm.ev(5'h08);
		exp_q.push_back(rsp(4'h2, 32'h0));
		pm.ev(5'h04);
		chk({30'h0, cause}, 36'h2);
		n = 0;
		while (exp_q.size() > 0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (exp_q.size() > 0) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, exp_q.size(), 0);
		end
		repeat (4) @(negedge clk);
		stop_test();
	end
endmodule
`default_nettype wire
